// file: core/fsps_map.vh
// Register map, field positions, command codes and timing figures of the
// flash self-programming sequencer. Included by the sequencer module only.
`ifndef FSPS_MAP_VH
`define FSPS_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define FSPS_ADDR_PROT_CMD   16'hffa0
`define FSPS_ADDR_STATUS     16'hffa1
`define FSPS_ADDR_MODE_CTL   16'hffa2
`define FSPS_ADDR_COMMAND    16'hffa3
`define FSPS_ADDR_PTR_HIGH   16'hffa4
`define FSPS_ADDR_PTR_LOW    16'hffa5
`define FSPS_ADDR_CMP_HIGH   16'hffa6
`define FSPS_ADDR_CMP_LOW    16'hffa7
`define FSPS_ADDR_WR_BUF     16'hffa8

// ****************************************************************
// Fields and values
// ****************************************************************
`define FSPS_UNLOCK_KEY      8'ha5
`define FSPS_BIT_MODE_SEL    0
`define FSPS_BIT_SEQ_ERR     0
`define FSPS_BIT_VERIFY_ERR  1
`define FSPS_BIT_PROT_ERR    2
`define FSPS_PROT_LSB        2
`define FSPS_BLANK_BYTE      8'hff
`define FSPS_PROTECT_ADDR    12'h081
`define FSPS_RESET_STATUS    3'h0

// ****************************************************************
// Command codes held in flash_command
// ****************************************************************
`define FSPS_CMD_NONE        8'h00
`define FSPS_CMD_VERIFY_BLK  8'h01
`define FSPS_CMD_VERIFY_RNG  8'h02
`define FSPS_CMD_ERASE       8'h03
`define FSPS_CMD_BLANK       8'h04
`define FSPS_CMD_WRITE       8'h05

// ****************************************************************
// Timing figures and clock rate
// ****************************************************************
`define FSPS_CLK_MHZ         50
`define FSPS_VERIFY_BLK_MS   6.8
`define FSPS_VERIFY_BYTE_US  27
`define FSPS_ERASE_MS        8.5
`define FSPS_BLANK_US        480
`define FSPS_WRITE_US        150
`define FSPS_ENTRY_MAX_US    10
`define FSPS_ENTRY_EXTRA_CLK 2

`endif

// file: core/fsps_timer.v
// Down counter that times one flash step of the sequencer.
// Assumes load is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps

module fsps_timer
(
  input  wire        clock,
  input  wire        nrst,
  input  wire        load,
  input  wire [18:0] load_val,
  output wire        expired
);

  reg [18:0] cnt_r;

  // Expired fires in the last counted cycle, so a load of N ends N cycles later.
  assign expired = (cnt_r == 19'h00001);

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= 19'h00000;
    else if (load)
      cnt_r <= load_val;
    else if (cnt_r != 19'h00000)
      cnt_r <= cnt_r - 19'h00001;
  end

endmodule // fsps_timer

// file: core/fsps_sequencer.v
// Flash self-programming sequencer: guarded mode entry, command registers,
// HALT-started flash operations and automatic HALT release.
// Assumes the CPU core pulses cpu_halt for one clock when it executes HALT,
// and the flash array answers fa_fail on the same clock.
//
// Contract
// - Self-programming mode is entered only through the protected write sequence.
// - HALT in self-programming mode starts the loaded flash command.
// - HALT is released by the sequencer itself when the operation ends.
// - Maskable interrupt servicing is blocked while self-programming mode is active.
// - Whole-block verify runs 6.8 ms from HALT to completion.
// - Range verify runs 27 us per byte verified.
// - Block erase takes 8.5 ms and leaves every byte reading FFH.
// - Block blank check ends 480 us after HALT.
// - Byte write programs one byte, ending 150 us after HALT.
// - CPU and RAM are stalled while a command runs.
// - Interrupts raised meanwhile stay pending until the mode is left.
// - After entry, NOP then HALT; release within 10 us plus 2 clocks.
// - Only the protect byte can block writes or erases, not security.
// - The protect byte at flash address 0081H governs allowed writes/erases.
// - Written flash data stays readable by ordinary data moves.
// - Pins hold their HALT-state levels during self-programming mode.
// - Mode write counts only after A5H, value, inverse, value; last write counts.
// - An unprotected mode write is discarded and sets the sequence error flag.
// - Mode select bit 0 means normal, 1 self-programming; cleared by reset.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "fsps_map.vh"

module fsps_sequencer
#(
  parameter integer VERIFY_BLK_CYC = `FSPS_VERIFY_BLK_MS * 1000 * `FSPS_CLK_MHZ,
  parameter integer ERASE_CYC      = `FSPS_ERASE_MS * 1000 * `FSPS_CLK_MHZ,
  parameter integer BLANK_CYC      = `FSPS_BLANK_US * `FSPS_CLK_MHZ,
  parameter integer WRITE_CYC      = `FSPS_WRITE_US * `FSPS_CLK_MHZ
)
(
  input  wire        clock,
  input  wire        nrst,
  input  wire [15:0] bus_addr,
  input  wire [7:0]  bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [7:0]  bus_rdata,
  input  wire        cpu_halt,
  output reg         cpu_release,
  output reg         cpu_stall,
  output reg         int_block,
  output reg         pin_hold,
  input  wire [4:0]  protect_byte,
  output reg         fa_go,
  output reg  [2:0]  fa_op,
  output reg  [11:0] fa_addr,
  output reg  [7:0]  fa_wdata,
  input  wire        fa_fail
);

  // ****************************************************************
  // Derived counts and states
  // ****************************************************************
  localparam integer ENTRY_CYC =
    `FSPS_ENTRY_MAX_US * `FSPS_CLK_MHZ + `FSPS_ENTRY_EXTRA_CLK;
  localparam integer BYTE_CYC = `FSPS_VERIFY_BYTE_US * `FSPS_CLK_MHZ;

  localparam [3:0] SQ_IDLE = 4'h1;
  localparam [3:0] SQ_KEY  = 4'h2;
  localparam [3:0] SQ_VAL  = 4'h4;
  localparam [3:0] SQ_INV  = 4'h8;

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN  = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  function [2:0] op_of;
    input [7:0] cmd;
    begin
      case (cmd)
        `FSPS_CMD_VERIFY_BLK: op_of = 3'h1;
        `FSPS_CMD_VERIFY_RNG: op_of = 3'h2;
        `FSPS_CMD_ERASE:      op_of = 3'h3;
        `FSPS_CMD_BLANK:      op_of = 3'h4;
        `FSPS_CMD_WRITE:      op_of = 3'h5;
        default:              op_of = 3'h0;
      endcase
    end
  endfunction

  function is_reg;
    input [15:0] a;
    input [15:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg [3:0]  seq_r;
  reg        seq_val_r;
  reg        mode_r;
  reg        entry_pend_r;
  reg [2:0]  status_r;
  reg [4:0]  prot_r;
  reg        prot_loaded_r;
  reg [7:0]  cmd_r;
  reg [7:0]  ptr_hi_r;
  reg [7:0]  ptr_lo_r;
  reg [7:0]  cmp_hi_r;
  reg [7:0]  cmp_lo_r;
  reg [7:0]  wbuf_r;
  reg [2:0]  st_r;
  reg [2:0]  op_r;
  reg [7:0]  byte_left_r;
  reg [7:0]  cur_lo_r;
  reg        tmr_load;
  reg [18:0] tmr_val;
  wire       tmr_exp;

  wire wr_pcmd = bus_wr && is_reg(bus_addr, `FSPS_ADDR_PROT_CMD);
  wire wr_mode = bus_wr && is_reg(bus_addr, `FSPS_ADDR_MODE_CTL);
  wire wr_stat = bus_wr && is_reg(bus_addr, `FSPS_ADDR_STATUS);
  wire wr_bit  = bus_wdata[`FSPS_BIT_MODE_SEL];
  wire [11:0] cur_addr = {ptr_hi_r[3:0], ptr_lo_r};
  // The block number is the upper nibble of the flash address.
  wire blocked = (ptr_hi_r[3:0] < prot_r[3:0]) || prot_r[4];
  wire [2:0] new_op = op_of(cmd_r);
  wire modifies = (new_op == 3'h3) || (new_op == 3'h5);

  fsps_timer u_timer
  (
    .clock    (clock),
    .nrst     (nrst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_exp)
  );

  // ****************************************************************
  // Protected mode-register write sequence
  // ****************************************************************
  reg [3:0] seq_nxt;
  reg       seq_err;
  reg       commit;

  always @*
  begin
    seq_nxt = seq_r;
    seq_err = 1'b0;
    commit  = 1'b0;
    if (bus_wr)
    begin
      case (seq_r)
        SQ_IDLE:
        begin
          if (wr_pcmd && bus_wdata == `FSPS_UNLOCK_KEY)
            seq_nxt = SQ_KEY;
          else if (wr_pcmd || wr_mode)
            seq_err = 1'b1;
        end
        SQ_KEY:
        begin
          seq_nxt = wr_mode ? SQ_VAL : SQ_IDLE;
          seq_err = !wr_mode;
        end
        SQ_VAL:
        begin
          seq_nxt = (wr_mode && wr_bit != seq_val_r) ? SQ_INV : SQ_IDLE;
          seq_err = !(wr_mode && wr_bit != seq_val_r);
        end
        SQ_INV:
        begin
          seq_nxt = SQ_IDLE;
          commit  = wr_mode && wr_bit == seq_val_r;
          seq_err = !commit;
        end
        default:
          seq_nxt = SQ_IDLE;
      endcase
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      seq_r        <= SQ_IDLE;
      seq_val_r    <= 1'b0;
      mode_r       <= 1'b0;
      entry_pend_r <= 1'b0;
    end
    else
    begin
      seq_r <= seq_nxt;
      if (seq_r == SQ_KEY && wr_mode)
        seq_val_r <= wr_bit;
      if (commit)
      begin
        mode_r       <= seq_val_r;
        entry_pend_r <= seq_val_r && !mode_r;
      end
      else if (st_r == ST_DONE)
        entry_pend_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      status_r      <= `FSPS_RESET_STATUS;
      prot_r        <= 5'h00;
      prot_loaded_r <= 1'b0;
      cmd_r         <= `FSPS_CMD_NONE;
      ptr_hi_r      <= 8'h00;
      ptr_lo_r      <= 8'h00;
      cmp_hi_r      <= 8'h00;
      cmp_lo_r      <= 8'h00;
      wbuf_r        <= 8'h00;
    end
    else
    begin
      // The protect byte is captured once, in the first cycle after reset.
      prot_loaded_r <= 1'b1;
      if (!prot_loaded_r)
        prot_r <= protect_byte;
      // A clear by software loses against a set in the same cycle.
      status_r[`FSPS_BIT_SEQ_ERR] <= seq_err ||
        (status_r[`FSPS_BIT_SEQ_ERR] && !(wr_stat && !bus_wdata[0]));
      status_r[`FSPS_BIT_VERIFY_ERR] <= (st_r == ST_RUN && tmr_exp && fa_fail) ||
        (status_r[`FSPS_BIT_VERIFY_ERR] && !(wr_stat && !bus_wdata[1]));
      status_r[`FSPS_BIT_PROT_ERR] <= (st_r == ST_IDLE && cpu_halt && mode_r &&
        !entry_pend_r && modifies && blocked) ||
        (status_r[`FSPS_BIT_PROT_ERR] && !(wr_stat && !bus_wdata[2]));
      if (bus_wr)
      begin
        case (bus_addr)
          `FSPS_ADDR_COMMAND:  cmd_r    <= bus_wdata;
          `FSPS_ADDR_PTR_HIGH: ptr_hi_r <= bus_wdata;
          `FSPS_ADDR_PTR_LOW:  ptr_lo_r <= bus_wdata;
          `FSPS_ADDR_CMP_HIGH: cmp_hi_r <= bus_wdata;
          `FSPS_ADDR_CMP_LOW:  cmp_lo_r <= bus_wdata;
          `FSPS_ADDR_WR_BUF:   wbuf_r   <= bus_wdata;
          default:             cmd_r    <= cmd_r;
        endcase
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      bus_rdata <= 8'h00;
    else if (bus_rd)
    begin
      case (bus_addr)
        `FSPS_ADDR_PROT_CMD: bus_rdata <= 8'h00;
        `FSPS_ADDR_STATUS:   bus_rdata <= {5'h00, status_r};
        `FSPS_ADDR_MODE_CTL: bus_rdata <= {1'b0, prot_r, 1'b0, mode_r};
        `FSPS_ADDR_COMMAND:  bus_rdata <= cmd_r;
        `FSPS_ADDR_PTR_HIGH: bus_rdata <= ptr_hi_r;
        `FSPS_ADDR_PTR_LOW:  bus_rdata <= ptr_lo_r;
        `FSPS_ADDR_CMP_HIGH: bus_rdata <= cmp_hi_r;
        `FSPS_ADDR_CMP_LOW:  bus_rdata <= cmp_lo_r;
        `FSPS_ADDR_WR_BUF:   bus_rdata <= wbuf_r;
        default:             bus_rdata <= 8'h00;
      endcase
    end
    else
      bus_rdata <= 8'h00;
  end

  // ****************************************************************
  // HALT-started operation
  // ****************************************************************
  always @*
  begin
    tmr_load = 1'b0;
    tmr_val  = 19'h00001;
    if (st_r == ST_IDLE && cpu_halt && mode_r)
    begin
      tmr_load = 1'b1;
      if (entry_pend_r)
        tmr_val = ENTRY_CYC[18:0];
      else if (modifies && blocked)
        tmr_val = 19'h00001;
      else
      begin
        case (new_op)
          3'h1:    tmr_val = VERIFY_BLK_CYC[18:0];
          3'h2:    tmr_val = BYTE_CYC[18:0];
          3'h3:    tmr_val = ERASE_CYC[18:0];
          3'h4:    tmr_val = BLANK_CYC[18:0];
          3'h5:    tmr_val = WRITE_CYC[18:0];
          default: tmr_val = 19'h00001;
        endcase
      end
    end
    else if (st_r == ST_RUN && tmr_exp && byte_left_r != 8'h00)
    begin
      tmr_load = 1'b1;
      tmr_val  = BYTE_CYC[18:0];
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r        <= ST_IDLE;
      op_r        <= 3'h0;
      byte_left_r <= 8'h00;
      cur_lo_r    <= 8'h00;
      cpu_release <= 1'b0;
      cpu_stall   <= 1'b0;
      fa_go       <= 1'b0;
      fa_op       <= 3'h0;
      fa_addr     <= 12'h000;
      fa_wdata    <= 8'h00;
    end
    else
    begin
      cpu_release <= 1'b0;
      fa_go       <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (cpu_halt && mode_r)
          begin
            st_r      <= ST_RUN;
            cpu_stall <= 1'b1;
            op_r      <= (entry_pend_r || (modifies && blocked)) ? 3'h0 : new_op;
            if (!entry_pend_r && !(modifies && blocked))
            begin
              fa_go    <= 1'b1;
              fa_op    <= new_op;
              fa_addr  <= cur_addr;
              // An erased byte reads back as the blank value.
              fa_wdata <= (new_op == 3'h3) ? `FSPS_BLANK_BYTE : wbuf_r;
            end
            byte_left_r <= (new_op == 3'h2) ? cmp_lo_r - ptr_lo_r : 8'h00;
            cur_lo_r    <= ptr_lo_r;
          end
        end
        ST_RUN:
        begin
          if (tmr_exp)
          begin
            if (op_r == 3'h2 && byte_left_r != 8'h00)
            begin
              byte_left_r <= byte_left_r - 8'h01;
              cur_lo_r    <= cur_lo_r + 8'h01;
              fa_go       <= 1'b1;
              fa_addr     <= {ptr_hi_r[3:0], cur_lo_r + 8'h01};
            end
            else
            begin
              st_r        <= ST_DONE;
              cpu_release <= 1'b1;
              cpu_stall   <= 1'b0;
              fa_op       <= 3'h0;
            end
          end
        end
        ST_DONE:
          st_r <= ST_IDLE;
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // System-facing mode levels
  // ****************************************************************
  // Interrupt requests are not dropped here; the controller keeps them
  // pending and only acknowledges once this level falls.
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      int_block <= 1'b0;
      pin_hold  <= 1'b0;
    end
    else
    begin
      int_block <= commit ? seq_val_r : mode_r;
      pin_hold  <= commit ? seq_val_r : mode_r;
    end
  end

endmodule // fsps_sequencer

// file: sim/fsps_seq_monitor.sv
// Port checker for the flash self-programming sequencer.
// Assumes one clock domain and step counts handed on by the bind.
`timescale 1ns/1ps

module fsps_seq_monitor
#(
  parameter integer VERIFY_BLK_CYC = 40,
  parameter integer ERASE_CYC      = 50,
  parameter integer BLANK_CYC      = 30,
  parameter integer WRITE_CYC      = 20
)
(
  input logic        clock,
  input logic        nrst,
  input logic [15:0] bus_addr,
  input logic [7:0]  bus_wdata,
  input logic        bus_wr,
  input logic        cpu_halt,
  input logic        cpu_release,
  input logic        cpu_stall,
  input logic        int_block,
  input logic        pin_hold,
  input logic        fa_go,
  input logic [2:0]  fa_op,
  input logic [7:0]  fa_wdata
);
  logic entry_pend_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // The first HALT after entering the mode only settles the array.
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      entry_pend_r <= 1'b0;
    else if (cpu_halt && pin_hold && !cpu_stall)
      entry_pend_r <= 1'b0;
    else if ($rose(pin_hold))
      entry_pend_r <= 1'b1;

  sequence s_halt_taken;
    cpu_halt && pin_hold && !cpu_stall && !cpu_release;
  endsequence

  sequence s_step(logic [2:0] op);
    s_halt_taken ##1 (fa_go && fa_op == op);
  endsequence

  a_release_pulse: assert property (cpu_release |=> !cpu_release && !cpu_stall)
    else $error("release longer than one cycle");
  a_go_stalls: assert property (fa_go |-> cpu_stall)
    else $error("flash step started without stall");
  a_halt_ignored: assert property (cpu_halt && !pin_hold |=> !cpu_stall && !fa_go)
    else $error("halt in normal mode started a step");
  a_int_in_mode: assert property (int_block == pin_hold && (pin_hold || !cpu_stall))
    else $error("interrupt block does not follow mode");
  a_mode_guarded: assert property ($rose(pin_hold) |-> $past(bus_wr) &&
    $past(bus_addr) == 16'hffa2 && $past(bus_wdata[0]))
    else $error("mode entered without a mode write");
  a_entry_release: assert property (s_halt_taken ##0 entry_pend_r |-> ##[2:503] cpu_release)
    else $error("entry halt not released in time");
  a_write_time: assert property (s_step(3'h5) |-> ##WRITE_CYC cpu_release)
    else $error("byte write time wrong");
  a_erase_time: assert property (s_step(3'h3) |-> fa_wdata == 8'hff ##ERASE_CYC cpu_release)
    else $error("block erase time or fill wrong");
  a_blank_time: assert property (s_step(3'h4) |-> ##BLANK_CYC cpu_release)
    else $error("blank check time wrong");
  a_verify_time: assert property (s_step(3'h1) |-> ##VERIFY_BLK_CYC cpu_release)
    else $error("block verify time wrong");
endmodule // fsps_seq_monitor

bind fsps_sequencer fsps_seq_monitor #(.VERIFY_BLK_CYC(VERIFY_BLK_CYC), .ERASE_CYC(ERASE_CYC),
  .BLANK_CYC(BLANK_CYC), .WRITE_CYC(WRITE_CYC)) fsps_seq_monitor_i (.clock(clock), .nrst(nrst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .cpu_halt(cpu_halt),
  .cpu_release(cpu_release), .cpu_stall(cpu_stall), .int_block(int_block),
  .pin_hold(pin_hold), .fa_go(fa_go), .fa_op(fa_op), .fa_wdata(fa_wdata));

// file: sim/fsps_flash_model.sv
// Behavioural flash array behind the sequencer: 16 blocks of 256 bytes.
// Assumes fa_go pulses once per step and fa_fail is sampled at step end.
`timescale 1ns/1ps

module fsps_flash_model
(
  input  logic        clock,
  input  logic        fa_go,
  input  logic [2:0]  fa_op,
  input  logic [11:0] fa_addr,
  input  logic [7:0]  fa_wdata,
  input  logic        inject_fail,
  output logic        fa_fail
);
  logic [7:0]  mem [0:4095];
  logic [15:0] blank_r = 16'h0000;

  always @(posedge clock)
  begin
    if (fa_go && fa_op == 3'h5)
    begin
      mem[fa_addr] <= fa_wdata;
      blank_r[fa_addr[11:8]] <= 1'b0;
    end
    else if (fa_go && fa_op == 3'h3)
    begin
      // Fill with the byte the sequencer supplies, so a wrong fill shows.
      for (int i = 0; i < 256; i++)
        mem[{fa_addr[11:8], i[7:0]}] <= fa_wdata;
      blank_r[fa_addr[11:8]] <= 1'b1;
    end
  end

  assign fa_fail = inject_fail || (fa_op == 3'h4 && !blank_r[fa_addr[11:8]]);
endmodule // fsps_flash_model

// file: sim/tb_top.sv
// Self-checking bench for the flash self-programming sequencer.
// Assumes shortened step counts and a protect byte locking blocks 0 and 1.
`timescale 1ns/1ps

module tb_top;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic        cpu_halt = 1'b0;
  logic        inject_fail = 1'b0;
  logic [7:0]  bus_rdata, fa_wdata, rv;
  logic        cpu_release, cpu_stall, int_block, pin_hold, fa_go, fa_fail;
  logic [2:0]  fa_op;
  logic [11:0] fa_addr;
  int          errors = 0;
  int          samples_checked = 0;
  int          n;

  always #10 clock = ~clock;

  fsps_sequencer #(.VERIFY_BLK_CYC(40), .ERASE_CYC(50), .BLANK_CYC(30), .WRITE_CYC(20))
    fsps_sequencer_i (.clock(clock), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_halt(cpu_halt),
    .cpu_release(cpu_release), .cpu_stall(cpu_stall), .int_block(int_block),
    .pin_hold(pin_hold), .protect_byte(5'h02), .fa_go(fa_go), .fa_op(fa_op),
    .fa_addr(fa_addr), .fa_wdata(fa_wdata), .fa_fail(fa_fail));

  fsps_flash_model fsps_flash_model_i (.clock(clock), .fa_go(fa_go), .fa_op(fa_op),
    .fa_addr(fa_addr), .fa_wdata(fa_wdata), .inject_fail(inject_fail), .fa_fail(fa_fail));

  // ****************************************************************
  // Bus, halt and compare tasks
  // ****************************************************************
  task automatic final_report();
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp)
    begin
      errors++;
      $display("[FAIL] %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  // Counts cycles from the edge that takes the halt to the release cycle.
  task automatic halt_run(output int cnt);
    @(posedge clock);
    cpu_halt <= 1'b1;
    @(posedge clock);
    cpu_halt <= 1'b0;
    cnt = 0;
    do
    begin
      @(posedge clock);
      #1;
      cnt++;
    end while (cpu_release !== 1'b1 && cnt < 3000);
    if (cnt >= 3000)
    begin
      errors++;
      $display("[FAIL] %0t halt never released", $time);
      final_report();
    end
  endtask

  task automatic mode_seq(input logic [7:0] v);
    // Clear the command register first, before the protected write sequence.
    wr(16'hffa3, 8'h00);
    wr(16'hffa0, 8'ha5);
    wr(16'hffa2, v);
    wr(16'hffa2, v ^ 8'h01);
    wr(16'hffa2, v);
  endtask

  task automatic run_cmd(input logic [7:0] cmd, hi, lo, cmp, input int expn);
    wr(16'hffa4, hi);
    wr(16'hffa5, lo);
    wr(16'hffa6, hi);
    wr(16'hffa7, cmp);
    wr(16'hffa8, lo ^ 8'h3c);
    wr(16'hffa3, cmd);
    halt_run(n);
    check_cnt(n, expn);
  endtask

  task automatic status_is(input logic [7:0] exp);
    rd(16'hffa1, rv);
    check8(rv, exp);
    wr(16'hffa1, 8'h00);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check8({5'h0, pin_hold, int_block, cpu_stall}, 8'h00);
    rd(16'hffa2, rv);
    check8(rv, 8'h08);
    rd(16'hffb0, rv);
    check8(rv, 8'h00);
    status_is(8'h00);
    $display("reset test done");
  endtask

  task automatic t_unlock_err();
    wr(16'hffa2, 8'h01);
    status_is(8'h01);
    status_is(8'h00);
    wr(16'hffa0, 8'ha5);
    wr(16'hffa2, 8'h01);
    wr(16'hffa2, 8'h01);
    wr(16'hffa2, 8'h01);
    check8({7'h0, pin_hold}, 8'h00);
    status_is(8'h01);
    $display("unlock error test done");
  endtask

  task automatic t_enter();
    mode_seq(8'h01);
    // The mode levels change at the commit edge, so look after it settles.
    #1;
    check8({6'h0, pin_hold, int_block}, 8'h03);
    rd(16'hffa2, rv);
    check8(rv, 8'h09);
    halt_run(n);
    check_cnt(n, 502);
    repeat (400) @(posedge clock);
    $display("entry test done");
  endtask

  task automatic t_commands();
    run_cmd(8'h03, 8'h02, 8'h00, 8'h00, 50);
    check8(fsps_flash_model_i.mem[12'h2ff], 8'hff);
    run_cmd(8'h04, 8'h02, 8'h00, 8'h00, 30);
    status_is(8'h00);
    run_cmd(8'h05, 8'h02, 8'h10, 8'h10, 20);
    check8(fsps_flash_model_i.mem[12'h210], 8'h2c);
    run_cmd(8'h04, 8'h02, 8'h00, 8'h00, 30);
    status_is(8'h02);
    run_cmd(8'h01, 8'h02, 8'h00, 8'h00, 40);
    inject_fail <= 1'b1;
    run_cmd(8'h01, 8'h02, 8'h00, 8'h00, 40);
    inject_fail <= 1'b0;
    status_is(8'h02);
    run_cmd(8'h02, 8'h02, 8'h10, 8'h11, 2700);
    status_is(8'h00);
    run_cmd(8'h03, 8'h00, 8'h00, 8'h00, 1);
    status_is(8'h04);
    run_cmd(8'h05, 8'h01, 8'h20, 8'h20, 1);
    status_is(8'h04);
    $display("command test done");
  endtask

  task automatic t_leave();
    mode_seq(8'h00);
    #1;
    check8({6'h0, pin_hold, int_block}, 8'h00);
    @(posedge clock);
    cpu_halt <= 1'b1;
    @(posedge clock);
    cpu_halt <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check8({6'h0, cpu_stall, fa_go}, 8'h00);
    $display("leave test done");
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_unlock_err();
    t_enter();
    t_commands();
    t_leave();
    final_report();
  end
endmodule // tb_top
